// File: bench/bvc_buck3_ctrl_sva.sv
module bvc_buck3_ctrl_sva #(
  parameter int BLANK_CYCLES = bvc_pkg::BVC_BLANK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire bvc_pkg::bvc_req_t req,
  input wire bvc_pkg::bvc_rsp_t rsp,
  input wire logic wr_reject,
  input wire logic wr_done,
  input wire logic password_unlocked,
  input wire logic ctrl_ready,
  // converter side
  input wire logic pulse_skip_enable,
  input wire logic [5:0] buck3_voltage_code,
  input wire logic [11:0] buck3_target_mv,
  input wire logic monitor_blank,
  input wire logic ov_fault,
  input wire logic uv_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  import bvc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic hit;
  logic ok;
  logic [7:0] wd_r;
  logic [7:0] old_r;
  int cnt_r;
  assign hit = req.addr == BVC_ADDR;
  assign ok = password_unlocked && ctrl_ready;
  always_ff @(posedge clk) begin
    wd_r <= req.wdata;
    old_r <= {pulse_skip_enable, 1'b0, buck3_voltage_code};
  end
  // rest of the window after wr_done, which is its first cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt_r <= 0;
    else if (wr_done) cnt_r <= 1;
    else if (cnt_r != 0 && cnt_r < BLANK_CYCLES - 1) cnt_r <= cnt_r + 1;
    else cnt_r <= 0;
  end
  function automatic logic [11:0] mv(input logic [5:0] c);
    if (c <= BVC_FINE_LAST) return 12'h384 + {6'h0, c} * 12'h019;
    return 12'h640 + {6'h0, c - BVC_COARSE_FIRST} * 12'h032;
  endfunction : mv
  rst_value_a: assert property (
    $rose(rstn) |-> pulse_skip_enable && buck3_voltage_code == 6'h3d)
    else $error("reset value wrong");
  no_stray_a: assert property (!(hit && req.rd) |=> !rsp.valid)
    else $error("read answer without request");
  rd_data_a: assert property (
    hit && req.rd |=> rsp.valid && rsp.data == old_r)
    else $error("read data wrong");
  wr_accept_a: assert property (
    hit && req.wr && ok |=> wr_done && !wr_reject)
    else $error("write not accepted");
  wr_refuse_a: assert property (
    hit && req.wr && !ok |=> wr_reject && !wr_done)
    else $error("write not refused");
  wr_store_a: assert property (
    hit && req.wr && ok |=>
    {pulse_skip_enable, buck3_voltage_code} == {wd_r[7], wd_r[5:0]})
    else $error("write not stored");
  blank_len_a: assert property (
    monitor_blank == (wr_done || cnt_r != 0))
    else $error("blank window length wrong");
  fault_gate_a: assert property (
    monitor_blank |=> !ov_fault && !uv_fault)
    else $error("fault during blank");
  target_map_a: assert property (
    buck3_target_mv == mv($past(buck3_voltage_code)))
    else $error("target voltage wrong");
endmodule : bvc_buck3_ctrl_sva

bind bvc_buck3_ctrl bvc_buck3_ctrl_sva #(.BLANK_CYCLES(BLANK_CYCLES)) u_sva (
  .clk(clk), .rstn(rstn), .req(req), .rsp(rsp), .wr_reject(wr_reject),
  .wr_done(wr_done), .password_unlocked(password_unlocked),
  .ctrl_ready(ctrl_ready), .pulse_skip_enable(pulse_skip_enable),
  .buck3_voltage_code(buck3_voltage_code),
  .buck3_target_mv(buck3_target_mv), .monitor_blank(monitor_blank),
  .ov_fault(ov_fault), .uv_fault(uv_fault)
);

// File: bench/bvc_host.sv
module bvc_host (
  // clock
  input wire logic clk,
  // register request
  output bvc_pkg::bvc_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  import bvc_pkg::*;
  initial req = '0;
  // caller unlocks first; idle bus shows junk so stale data never hits
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(negedge clk);
    req <= '{a, w, !w, d};
    @(negedge clk);
    req <= '{~a, 1'b0, 1'b0, ~d};
  endtask : xfer
endmodule : bvc_host

// File: bench/tb_bvc_buck3_ctrl.sv
module tb_bvc_buck3_ctrl import bvc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BLANK = 20;
  logic clk, rstn, unlocked, ov, uv, wr_reject, wr_done, pse, ready, blank;
  logic ov_fault, uv_fault;
  logic [1:0] strap;
  logic [5:0] code;
  logic [11:0] mv;
  logic [7:0] d;
  logic [31:0] seed = 32'h3b0a7b79;
  logic [7:0] corner [4] = '{8'h40, 8'h1a, 8'h5b, 8'hff};
  bvc_req_t req;
  bvc_rsp_t rsp;
  int error_cnt, samples_checked, cyc;
  // distinct strap entries so a wrong index shows
  bvc_buck3_ctrl #(.BLANK_CYCLES(BLANK),
    .STRAP_CODES({6'h3d, 6'h15, 6'h2a, 6'h05})) uut (
    .clk(clk), .rstn(rstn), .req(req), .rsp(rsp), .wr_reject(wr_reject),
    .wr_done(wr_done), .password_unlocked(unlocked),
    .resistor_select_strap(strap), .pulse_skip_enable(pse),
    .buck3_voltage_code(code), .buck3_target_mv(mv), .ctrl_ready(ready),
    .ov_raw(ov), .uv_raw(uv), .monitor_blank(blank), .ov_fault(ov_fault),
    .uv_fault(uv_fault));
  bvc_host host (.clk(clk), .req(req));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [11:0] calc_mv(input logic [5:0] c);
    if (c < 6'h1b) return 12'h384 + {6'h0, c} * 12'h019;
    return 12'h640 + {6'h0, c - 6'h1b} * 12'h032;
  endfunction : calc_mv
  task automatic chk(input string n, input logic [11:0] e, s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd(input logic [7:0] e);
    host.xfer(1'b0, BVC_ADDR, 8'h00);
    chk("rd_valid", 12'h001, {11'h0, rsp.valid});
    chk("rd_data", {4'h0, e}, {4'h0, rsp.data});
  endtask : rd
  task automatic boot(input logic [1:0] s);
    rstn = 1'b0;
    strap = s;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 10 && ready !== 1'b1; i++) @(negedge clk);
    chk("ready", 12'h001, {11'h0, ready});
  endtask : boot
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    unlocked = 1'b0;
    ov = 1'b0;
    uv = 1'b0;
    boot(2'h2);
    rd(8'h95);
    host.xfer(1'b1, BVC_ADDR, 8'h00);
    chk("reject", 12'h001, {11'h0, wr_reject});
    chk("no_blank", 12'h000, {11'h0, blank});
    rd(8'h95);
    unlocked = 1'b1;
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      d = i < 4 ? corner[i] : seed[7:0];
      host.xfer(1'b1, BVC_ADDR, d);
      chk("done", 12'h001, {11'h0, wr_done});
      chk("blank", 12'h001, {11'h0, blank});
      chk("code", {6'h0, d[5:0]}, {6'h0, code});
      chk("pse", {11'h0, d[7]}, {11'h0, pse});
      rd({d[7], 1'b0, d[5:0]});
      chk("target", calc_mv(d[5:0]), mv);
    end
    ov = 1'b1;
    uv = 1'b1;
    repeat (BLANK - 6) @(negedge clk);
    chk("ov_blanked", 12'h000, {11'h0, ov_fault});
    repeat (8) @(negedge clk);
    chk("blank_end", 12'h000, {11'h0, blank});
    chk("faults", 12'h003, {10'h0, ov_fault, uv_fault});
    host.xfer(1'b1, BVC_ADDR, 8'hbd);
    @(negedge clk);
    chk("refault", 12'h000, {10'h0, ov_fault, uv_fault});
    host.xfer(1'b0, 8'h19, 8'h00);
    chk("stray_rd", 12'h000, {11'h0, rsp.valid});
    host.xfer(1'b1, 8'h19, 8'hc0);
    chk("stray_wr", 12'h000, {11'h0, wr_done});
    rd(8'hbd);
    boot(2'h0);
    rd(8'h85);
    results();
  end
endmodule : tb_bvc_buck3_ctrl

// File: core/bvc_blank_timer.sv
module bvc_blank_timer #(
  parameter int CYCLES = 1250000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // restart and window
  input wire logic start,
  output logic blank
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic blank_r;

  if (CYCLES < 1) begin : g_bad_cycles
    $error("bvc_blank_timer: CYCLES must be at least 1");
  end

  // a fresh write restarts the whole window, never extends a partial one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= LOAD;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blank_r <= 1'b0;
    end else if (start) begin
      blank_r <= 1'b1;
    end else if (cnt_r == '0) begin
      blank_r <= 1'b0;
    end
  end

  assign blank = blank_r;

endmodule : bvc_blank_timer

// File: core/bvc_buck3_ctrl.sv
// Operation
// - register at 0x18, reset value 0xbd
// - writes need password unlock first
// - each accepted write blanks voltage monitors 5 ms
// - bit 7: 0 forced pwm, 1 pulse-skip
// - codes 0..1a: 0.900 V up 25 mV
// - codes 1b..3f: 1.600 V up 50 mV
// - power-up code may follow resistor strap
module bvc_buck3_ctrl #(
  parameter int BLANK_CYCLES = bvc_pkg::BVC_BLANK_CYC,
  parameter logic [4*6-1:0] STRAP_CODES = {4{bvc_pkg::BVC_CODE_RESET}}
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register access from the serial interface front end
  input wire bvc_pkg::bvc_req_t req,
  output bvc_pkg::bvc_rsp_t rsp,
  output logic wr_reject,
  output logic wr_done,
  // password state from the unlock logic
  input wire logic password_unlocked,
  // strap pin
  input wire logic [bvc_pkg::BVC_STRAP_W-1:0] resistor_select_strap,
  // converter controls
  output logic pulse_skip_enable,
  output logic [5:0] buck3_voltage_code,
  output logic [11:0] buck3_target_mv,
  output logic ctrl_ready,
  // voltage monitors, raw comparator levels in
  input wire logic ov_raw,
  input wire logic uv_raw,
  output logic monitor_blank,
  output logic ov_fault,
  output logic uv_fault
);
  import bvc_pkg::*;

  if (BVC_STRAP_W != 2) begin : g_bad_strap
    $error("bvc_buck3_ctrl: strap table sized for two strap bits");
  end

  // code to target voltage, in millivolts
  function automatic logic [11:0] code_to_mv(input logic [5:0] code);
    logic [11:0] c;
    c = {6'h00, code};
    if (code <= BVC_FINE_LAST) begin
      code_to_mv = BVC_FINE_BASE_MV + 12'(c * BVC_FINE_STEP_MV);
    end else begin
      code_to_mv = BVC_COARSE_BASE_MV +
        12'((c - {6'h00, BVC_COARSE_FIRST}) * BVC_COARSE_STEP_MV);
    end
  endfunction : code_to_mv

  // register read view, reserved bit forced low
  function automatic logic [7:0] reg_view(input logic pse,
                                          input logic [5:0] code);
    logic [7:0] v;
    v = 8'h00;
    v[BVC_PSE_BIT] = pse;
    v[BVC_RSV_BIT] = 1'b0;
    v[BVC_CODE_LSB +: BVC_CODE_W] = code;
    reg_view = v;
  endfunction : reg_view

  localparam logic [11:0] MV_RESET = code_to_mv(BVC_CODE_RESET);

  bvc_state_t state_r;
  bvc_state_t state_nxt;

  logic [1:0] strap_s1_r;
  logic [1:0] strap_s2_r;
  logic ov_s1_r;
  logic ov_s2_r;
  logic uv_s1_r;
  logic uv_s2_r;

  logic pse_r;
  logic [5:0] code_r;
  logic [11:0] mv_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic wr_reject_r;
  logic wr_done_r;
  logic ov_fault_r;
  logic uv_fault_r;

  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic wr_ok;
  logic blank;

  assign hit = (req.addr == BVC_ADDR);
  assign wr_hit = req.wr & hit;
  assign rd_hit = req.rd & hit;
  // locked or still loading the strap: the write is dropped
  assign wr_ok = wr_hit & password_unlocked & (state_r == BVC_ST_RUN);

  // strap and comparators come from outside the clock domain;
  // strap sync not reset: it settles during reset, ready for the load state
  always_ff @(posedge clk) begin
    strap_s1_r <= resistor_select_strap;
    strap_s2_r <= strap_s1_r;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ov_s1_r <= 1'b0;
      ov_s2_r <= 1'b0;
      uv_s1_r <= 1'b0;
      uv_s2_r <= 1'b0;
    end else begin
      ov_s1_r <= ov_raw;
      ov_s2_r <= ov_s1_r;
      uv_s1_r <= uv_raw;
      uv_s2_r <= uv_s1_r;
    end
  end

  // power-up sequence: wait for synced strap, load once, then run
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      BVC_ST_SYNC: begin
        state_nxt = BVC_ST_LOAD;
      end
      BVC_ST_LOAD: begin
        state_nxt = BVC_ST_RUN;
      end
      BVC_ST_RUN: begin
        state_nxt = BVC_ST_RUN;
      end
      default: begin
        state_nxt = BVC_ST_SYNC;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= BVC_ST_SYNC;
    end else begin
      state_r <= state_nxt;
    end
  end

  // mode bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pse_r <= BVC_PSE_RESET;
    end else if (wr_ok) begin
      pse_r <= req.wdata[BVC_PSE_BIT];
    end
  end

  // voltage code; strap value replaces the nominal one after reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      code_r <= BVC_CODE_RESET;
    end else if (state_r == BVC_ST_LOAD) begin
      code_r <= STRAP_CODES[int'(strap_s2_r) * 6 +: 6];
    end else if (wr_ok) begin
      code_r <= req.wdata[BVC_CODE_LSB +: BVC_CODE_W];
    end
  end

  // target lags the code by one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mv_r <= MV_RESET;
    end else begin
      mv_r <= code_to_mv(code_r);
    end
  end

  // read answer, one cycle after the request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      rvalid_r <= rd_hit;
      if (rd_hit) begin
        rdata_r <= reg_view(pse_r, code_r);
      end
    end
  end

  // write outcome pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_done_r <= 1'b0;
      wr_reject_r <= 1'b0;
    end else begin
      wr_done_r <= wr_ok;
      wr_reject_r <= wr_hit & ~wr_ok;
    end
  end

  // any accepted write restarts blanking, even an unchanged value
  bvc_blank_timer #(
    .CYCLES(BLANK_CYCLES)
  ) u_blank (
    .clk(clk),
    .rstn(rstn),
    .start(wr_ok),
    .blank(blank)
  );

  // faults are held low one cycle behind the blank window (registered from ~blank) so a step does not trip them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ov_fault_r <= 1'b0;
      uv_fault_r <= 1'b0;
    end else begin
      ov_fault_r <= ov_s2_r & ~blank;
      uv_fault_r <= uv_s2_r & ~blank;
    end
  end

  assign rsp.valid = rvalid_r;
  assign rsp.data = rdata_r;
  assign wr_reject = wr_reject_r;
  assign wr_done = wr_done_r;
  assign pulse_skip_enable = pse_r;
  assign buck3_voltage_code = code_r;
  assign buck3_target_mv = mv_r;
  assign ctrl_ready = (state_r == BVC_ST_RUN);
  assign monitor_blank = blank;
  assign ov_fault = ov_fault_r;
  assign uv_fault = uv_fault_r;

endmodule : bvc_buck3_ctrl

// File: core/bvc_pkg.sv
package bvc_pkg;

  // register location and layout
  localparam logic [7:0] BVC_ADDR = 8'h18;
  localparam logic [7:0] BVC_RESET = 8'hbd;
  localparam int BVC_PSE_BIT = 7;
  localparam int BVC_RSV_BIT = 6;
  localparam int BVC_CODE_LSB = 0;
  localparam int BVC_CODE_W = 6;
  localparam logic BVC_PSE_RESET = 1'b1;
  localparam logic [5:0] BVC_CODE_RESET = 6'h3d;

  // voltage code map, millivolts
  localparam logic [5:0] BVC_FINE_LAST = 6'h1a;
  localparam logic [5:0] BVC_COARSE_FIRST = 6'h1b;
  localparam logic [11:0] BVC_FINE_BASE_MV = 12'h384;
  localparam logic [11:0] BVC_FINE_STEP_MV = 12'h019;
  localparam logic [11:0] BVC_COARSE_BASE_MV = 12'h640;
  localparam logic [11:0] BVC_COARSE_STEP_MV = 12'h032;

  // monitor blanking after a write
  localparam int BVC_BLANK_MS = 5;
  localparam int BVC_CLK_KHZ = 250000;
  localparam int BVC_BLANK_CYC = BVC_BLANK_MS * BVC_CLK_KHZ;

  // strap
  localparam int BVC_STRAP_W = 2;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } bvc_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } bvc_rsp_t;

  typedef enum logic [2:0] {
    BVC_ST_SYNC = 3'b001,
    BVC_ST_LOAD = 3'b010,
    BVC_ST_RUN = 3'b100
  } bvc_state_t;

endpackage : bvc_pkg
